/* File: rtl/mpb_bank.v */
`timescale 1ns/10ps
// Overview of operation
// - clamp reference speed to ceiling in ramped modes
// - hold 16-bit start/stop speed parameter
// - quick-stop decel applied on stop or class-1
// - quick-stop decel 32-bit, 200..3000000, default 6000
// - symmetric ramp 16-bit, unit 10 rpm/s
// - symmetric ramp write sets accel and decel
// - symmetric ramp write checked against both limits
// - symmetric ramp read returns larger ramp
// - symmetric ramp read saturates at 0xffff
// - nominal current 16-bit, 10 mA steps
// - torque speeds auto-filled, read-only on predefined motor
// - motor speed limit 1..3000, default 3000
// - limit select 0 none,1 pos,2 neg,3 both
// - limit monitoring only when homing valid
// - out-of-range limit position becomes max user value
// - limit positions signed 32-bit, extreme defaults
// - modes mask bits 0,2,5 pp,pv,homing
// - modes mask bits 16..22 jog through oscillator
module mpb_bank (
    input wire CLK, // 40 MHz clock
    input wire RST, // async reset, active high
    input wire WR_EN, // word write strobe
    input wire RD_EN, // word read strobe
    input wire [15:0] ADDR, // fieldbus register address
    input wire [15:0] WR_DATA, // write word
    output reg [15:0] RD_DATA, // read word
    output reg RD_VALID, // read data valid pulse
    output reg WR_ERR, // write rejected pulse
    input wire PREDEF_MOTOR, // predefined motor selected
    input wire [15:0] PREDEF_SPD20, // catalogue 20 pct speed
    input wire [15:0] PREDEF_SPD50, // catalogue 50 pct speed
    input wire [15:0] PREDEF_SPD90, // catalogue 90 pct speed
    input wire [31:0] USER_POS_MIN, // permissible user range low
    input wire [31:0] USER_POS_MAX, // permissible user range high
    input wire HOMING_VALID, // homing completed
    input wire SW_STOP, // software stop request
    input wire ERR_CLASS1, // class 1 error active
    input wire [2:0] OP_MODE, // active operating mode
    input wire [31:0] REF_SPEED, // commanded reference speed
    output reg [31:0] REF_SPEED_LIM, // clamped reference speed
    output reg [31:0] ACTIVE_DECEL, // decel used by generator
    output reg [31:0] PROFILE_ACCEL, // acceleration in use
    output reg [15:0] START_STOP_SPEED, // start and end speed
    output reg [15:0] MOTOR_SPEED_LIMIT, // max motor speed
    output reg [15:0] NOMINAL_CURRENT, // nominal current 10 mA
    output reg SOFT_LIMIT_POS_ENABLE, // positive limit monitored
    output reg SOFT_LIMIT_NEG_ENABLE, // negative limit monitored
    output reg [31:0] SOFT_LIMIT_POS, // positive limit position
    output reg [31:0] SOFT_LIMIT_NEG // negative limit position
);
`include "mpb_map.vh"

////////////////////////////////////////////////////////////////////////
reg [15:0] ref_speed_ceiling_r;
reg [15:0] start_stop_speed_r;
reg [31:0] quick_stop_decel_r;
reg [31:0] profile_accel_r;
reg [31:0] profile_decel_r;
reg [15:0] motor_speed_limit_r;
reg [15:0] nominal_motor_current_r;
reg [15:0] spd90_r;
reg [15:0] spd50_r;
reg [15:0] spd20_r;
reg [15:0] soft_limit_monitor_select_r;
reg [31:0] soft_limit_positive_position_r;
reg [31:0] soft_limit_negative_position_r;
// high half of a 32-bit write, held until the low half arrives
reg [15:0] hi_latch_r;
reg [15:0] hi_addr_r;
reg hi_valid_r;
reg [15:0] lo_hold_r;
wire signed [31:0] clamp_out;

////////////////////////////////////////////////////////////////////////
// a 32-bit write is hi word at base, then lo word at base+1
wire [15:0] base_addr = ADDR - 16'h0001;
wire lo_word = hi_valid_r && (hi_addr_r == base_addr);
wire [31:0] wr32 = {hi_latch_r, WR_DATA};
wire [31:0] sym32 = {16'h0000, WR_DATA};
wire [31:0] modes_val = `MPB_MODES_VAL;
wire [31:0] sym_val = sym32 * 32'h0000000a;
wire ramp_big = profile_accel_r > profile_decel_r;
wire [31:0] ramp_max = ramp_big ? profile_accel_r : profile_decel_r;
wire [31:0] ramp_units = ramp_max / 32'h0000000a;
wire pos_in_rng = ($signed(wr32) >= $signed(USER_POS_MIN)) &&
                  ($signed(wr32) <= $signed(USER_POS_MAX));
wire is_32 = (ADDR == `MPB_A_LIM_POS) || (ADDR == `MPB_A_LIM_NEG) ||
             (ADDR == `MPB_A_QSTOP) || (ADDR == `MPB_A_PROF_ACC) ||
             (ADDR == `MPB_A_PROF_DEC) || (ADDR == `MPB_A_MODES);

////////////////////////////////////////////////////////////////////////
always @(posedge CLK or posedge RST) begin
    if (RST) begin
        ref_speed_ceiling_r <= `MPB_CEIL_RST;
        start_stop_speed_r <= `MPB_START_RST;
        quick_stop_decel_r <= `MPB_QSTOP_RST;
        profile_accel_r <= `MPB_ACC_RST;
        profile_decel_r <= `MPB_DEC_RST;
        motor_speed_limit_r <= `MPB_SPD_RST;
        nominal_motor_current_r <= `MPB_NOM_CUR_RST;
        spd90_r <= 16'h0000;
        spd50_r <= 16'h0000;
        spd20_r <= 16'h0000;
        soft_limit_monitor_select_r <= `MPB_LIM_SEL_RST;
        soft_limit_positive_position_r <= `MPB_LIM_POS_RST;
        soft_limit_negative_position_r <= `MPB_LIM_NEG_RST;
        hi_latch_r <= 16'h0000;
        hi_addr_r <= 16'h0000;
        hi_valid_r <= 1'b0;
        WR_ERR <= 1'b0;
    end else begin
        WR_ERR <= 1'b0;
        if (PREDEF_MOTOR) begin
            spd90_r <= PREDEF_SPD90;
            spd50_r <= PREDEF_SPD50;
            spd20_r <= PREDEF_SPD20;
        end
        if (WR_EN) begin
            hi_valid_r <= 1'b0;
            if (is_32) begin
                hi_latch_r <= WR_DATA;
                hi_addr_r <= ADDR;
                hi_valid_r <= (ADDR != `MPB_A_MODES);
                WR_ERR <= (ADDR == `MPB_A_MODES);
            end else if (lo_word) begin
                case (hi_addr_r)
                    `MPB_A_QSTOP: begin
                        if (wr32 >= `MPB_QSTOP_MIN && wr32 <= `MPB_QSTOP_MAX) begin
                            quick_stop_decel_r <= wr32;
                        end else begin
                            WR_ERR <= 1'b1;
                        end
                    end
                    `MPB_A_PROF_ACC: begin
                        if (wr32 >= `MPB_ACC_MIN && wr32 <= `MPB_ACC_MAX) begin
                            profile_accel_r <= wr32;
                        end else begin
                            WR_ERR <= 1'b1;
                        end
                    end
                    `MPB_A_PROF_DEC: begin
                        if (wr32 >= `MPB_DEC_MIN && wr32 <= `MPB_DEC_MAX) begin
                            profile_decel_r <= wr32;
                        end else begin
                            WR_ERR <= 1'b1;
                        end
                    end
                    `MPB_A_LIM_POS: begin
                        // out-of-range entries snap to the top of the user range
                        soft_limit_positive_position_r <= pos_in_rng ? wr32 :
                                                          USER_POS_MAX;
                    end
                    `MPB_A_LIM_NEG: begin
                        soft_limit_negative_position_r <= pos_in_rng ? wr32 :
                                                          USER_POS_MAX;
                    end
                    default: begin
                        WR_ERR <= 1'b1;
                    end
                endcase
            end else begin
                case (ADDR)
                    `MPB_A_SYM_RAMP: begin
                        // one value must suit both ramps or neither changes
                        if (sym_val >= `MPB_ACC_MIN && sym_val <= `MPB_ACC_MAX &&
                            sym_val >= `MPB_DEC_MIN && sym_val <= `MPB_DEC_MAX) begin
                            profile_accel_r <= sym_val;
                            profile_decel_r <= sym_val;
                        end else begin
                            WR_ERR <= 1'b1;
                        end
                    end
                    `MPB_A_LIM_SEL: begin
                        if (WR_DATA <= `MPB_LIM_SEL_MAX) begin
                            soft_limit_monitor_select_r <= WR_DATA;
                        end else begin
                            WR_ERR <= 1'b1;
                        end
                    end
                    `MPB_A_REF_CEIL: begin
                        if (WR_DATA >= `MPB_CEIL_MIN && WR_DATA <= `MPB_CEIL_MAX) begin
                            ref_speed_ceiling_r <= WR_DATA;
                        end else begin
                            WR_ERR <= 1'b1;
                        end
                    end
                    `MPB_A_START_STOP: start_stop_speed_r <= WR_DATA;
                    `MPB_A_SPD_LIMIT: begin
                        if (WR_DATA >= `MPB_SPD_MIN && WR_DATA <= `MPB_SPD_MAX) begin
                            motor_speed_limit_r <= WR_DATA;
                        end else begin
                            WR_ERR <= 1'b1;
                        end
                    end
                    `MPB_A_NOM_CUR: nominal_motor_current_r <= WR_DATA;
                    `MPB_A_SPD90: begin
                        if (PREDEF_MOTOR) WR_ERR <= 1'b1;
                        else spd90_r <= WR_DATA;
                    end
                    `MPB_A_SPD50: begin
                        if (PREDEF_MOTOR) WR_ERR <= 1'b1;
                        else spd50_r <= WR_DATA;
                    end
                    `MPB_A_SPD20: begin
                        if (PREDEF_MOTOR) WR_ERR <= 1'b1;
                        else spd20_r <= WR_DATA;
                    end
                    default: WR_ERR <= 1'b1;
                endcase
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////
// reads: hi word at base, lo word at base+1 from a snapshot taken with hi
always @(posedge CLK or posedge RST) begin
    if (RST) begin
        RD_DATA <= 16'h0000;
        RD_VALID <= 1'b0;
        lo_hold_r <= 16'h0000;
    end else begin
        RD_VALID <= RD_EN;
        if (RD_EN) begin
            case (ADDR)
                `MPB_A_SYM_RAMP: begin
                    RD_DATA <= (ramp_units > 32'h0000ffff) ? `MPB_SYM_SAT :
                               ramp_units[15:0];
                end
                `MPB_A_LIM_SEL: RD_DATA <= soft_limit_monitor_select_r;
                `MPB_A_LIM_POS: begin
                    RD_DATA <= soft_limit_positive_position_r[31:16];
                    lo_hold_r <= soft_limit_positive_position_r[15:0];
                end
                `MPB_A_LIM_NEG: begin
                    RD_DATA <= soft_limit_negative_position_r[31:16];
                    lo_hold_r <= soft_limit_negative_position_r[15:0];
                end
                `MPB_A_QSTOP: begin
                    RD_DATA <= quick_stop_decel_r[31:16];
                    lo_hold_r <= quick_stop_decel_r[15:0];
                end
                `MPB_A_PROF_ACC: begin
                    RD_DATA <= profile_accel_r[31:16];
                    lo_hold_r <= profile_accel_r[15:0];
                end
                `MPB_A_PROF_DEC: begin
                    RD_DATA <= profile_decel_r[31:16];
                    lo_hold_r <= profile_decel_r[15:0];
                end
                `MPB_A_MODES: begin
                    RD_DATA <= modes_val[31:16];
                    lo_hold_r <= modes_val[15:0];
                end
                `MPB_A_LIM_POS + 16'h0001, `MPB_A_LIM_NEG + 16'h0001,
                `MPB_A_QSTOP + 16'h0001, `MPB_A_PROF_ACC + 16'h0001,
                `MPB_A_PROF_DEC + 16'h0001, `MPB_A_MODES + 16'h0001: RD_DATA <= lo_hold_r;
                `MPB_A_REF_CEIL: RD_DATA <= ref_speed_ceiling_r;
                `MPB_A_START_STOP: RD_DATA <= start_stop_speed_r;
                `MPB_A_SPD_LIMIT: RD_DATA <= motor_speed_limit_r;
                `MPB_A_NOM_CUR: RD_DATA <= nominal_motor_current_r;
                `MPB_A_SPD90: RD_DATA <= spd90_r;
                `MPB_A_SPD50: RD_DATA <= spd50_r;
                `MPB_A_SPD20: RD_DATA <= spd20_r;
                default: RD_DATA <= 16'h0000;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////
mpb_clamp u_clamp (
    .mode(OP_MODE),
    .ref_in(REF_SPEED),
    .ceiling(ref_speed_ceiling_r),
    .ref_out(clamp_out)
);

// registered outputs toward the motion generator
always @(posedge CLK or posedge RST) begin
    if (RST) begin
        REF_SPEED_LIM <= 32'h00000000;
        ACTIVE_DECEL <= `MPB_DEC_RST;
        PROFILE_ACCEL <= `MPB_ACC_RST;
        START_STOP_SPEED <= `MPB_START_RST;
        MOTOR_SPEED_LIMIT <= `MPB_SPD_RST;
        NOMINAL_CURRENT <= `MPB_NOM_CUR_RST;
        SOFT_LIMIT_POS_ENABLE <= 1'b0;
        SOFT_LIMIT_NEG_ENABLE <= 1'b0;
        SOFT_LIMIT_POS <= `MPB_LIM_POS_RST;
        SOFT_LIMIT_NEG <= `MPB_LIM_NEG_RST;
    end else begin
        REF_SPEED_LIM <= clamp_out;
        // stop paths take the steeper quick-stop ramp
        ACTIVE_DECEL <= (SW_STOP || ERR_CLASS1) ? quick_stop_decel_r :
                        profile_decel_r;
        PROFILE_ACCEL <= profile_accel_r;
        START_STOP_SPEED <= start_stop_speed_r;
        MOTOR_SPEED_LIMIT <= motor_speed_limit_r;
        NOMINAL_CURRENT <= nominal_motor_current_r;
        SOFT_LIMIT_POS_ENABLE <= HOMING_VALID && soft_limit_monitor_select_r[0];
        SOFT_LIMIT_NEG_ENABLE <= HOMING_VALID && soft_limit_monitor_select_r[1];
        SOFT_LIMIT_POS <= soft_limit_positive_position_r;
        SOFT_LIMIT_NEG <= soft_limit_negative_position_r;
    end
end
endmodule

/* File: rtl/mpb_map.vh */
`ifndef MPB_MAP_VH
`define MPB_MAP_VH
// register addresses, 16-bit word addresses
`define MPB_A_SYM_RAMP 16'h0602
`define MPB_A_LIM_SEL 16'h0606
`define MPB_A_LIM_POS 16'h0608
`define MPB_A_LIM_NEG 16'h060a
`define MPB_A_PROF_ACC 16'h0614
`define MPB_A_PROF_DEC 16'h0616
`define MPB_A_REF_CEIL 16'h0612
`define MPB_A_START_STOP 16'h0622
`define MPB_A_QSTOP 16'h0624
`define MPB_A_SPD_LIMIT 16'h0e08
`define MPB_A_NOM_CUR 16'h0e0c
`define MPB_A_SPD90 16'h0e14
`define MPB_A_SPD50 16'h0e16
`define MPB_A_SPD20 16'h0e18
`define MPB_A_MODES 16'h1b28
// reset values and limits
`define MPB_QSTOP_MIN 32'h000000c8
`define MPB_QSTOP_RST 32'h00001770
`define MPB_QSTOP_MAX 32'h002dc6c0
`define MPB_ACC_MIN 32'h00000001
`define MPB_ACC_RST 32'h00000258
`define MPB_ACC_MAX 32'h002dc6c0
`define MPB_DEC_MIN 32'h000000c8
`define MPB_DEC_RST 32'h000002ee
`define MPB_DEC_MAX 32'h002dc6c0
`define MPB_SPD_MIN 16'h0001
`define MPB_SPD_RST 16'h0bb8
`define MPB_SPD_MAX 16'h0bb8
`define MPB_CEIL_MIN 16'h003c
`define MPB_CEIL_RST 16'h3390
`define MPB_CEIL_MAX 16'h3390
`define MPB_LIM_SEL_RST 16'h0000
`define MPB_LIM_SEL_MAX 16'h0003
`define MPB_LIM_POS_RST 32'h7fffffff
`define MPB_LIM_NEG_RST 32'h80000000
`define MPB_START_RST 16'h0000
`define MPB_NOM_CUR_RST 16'h0000
`define MPB_SYM_SAT 16'hffff
// supported mode bit positions
`define MPB_MB_PP 0
`define MPB_MB_PV 2
`define MPB_MB_HOME 5
`define MPB_MB_JOG 16
`define MPB_MB_OSC 22
`define MPB_MODES_VAL 32'h007f0025
// mode selector values for the motion generator
`define MPB_OPM_PP 3'h1
`define MPB_OPM_PV 3'h2
`define MPB_OPM_HOME 3'h3
`define MPB_OPM_JOG 3'h4
`endif

/* File: rtl/mpb_clamp.v */
`timescale 1ns/10ps
// ceiling clamp for the commanded speed, only in ramped modes
module mpb_clamp (
    input wire [2:0] mode, // active operating mode
    input wire signed [31:0] ref_in, // commanded reference speed
    input wire [15:0] ceiling, // reference speed ceiling
    output reg signed [31:0] ref_out // limited reference speed
);
`include "mpb_map.vh"
reg ramped;
reg signed [31:0] ceil_s;
always @* begin
    ramped = (mode == `MPB_OPM_PP) || (mode == `MPB_OPM_PV) ||
             (mode == `MPB_OPM_HOME) || (mode == `MPB_OPM_JOG);
    ceil_s = $signed({16'h0000, ceiling});
    ref_out = ref_in;
    // magnitude limited both ways so reverse moves obey it too
    if (ramped && ref_in > ceil_s) begin
        ref_out = ceil_s;
    end else if (ramped && ref_in < -ceil_s) begin
        ref_out = -ceil_s;
    end
end
endmodule

/* File: testbench/mpb_bank_props.sv */
`timescale 1ns/10ps
module mpb_bank_props (
    input wire CLK, // clock
    input wire RST, // reset
    input wire WR_EN, // write strobe
    input wire [15:0] ADDR, // address
    input wire [15:0] WR_DATA, // write word
    input wire WR_ERR, // reject pulse
    input wire RD_EN, // read strobe
    input wire RD_VALID, // read valid pulse
    input wire PREDEF_MOTOR, // catalogue motor
    input wire HOMING_VALID, // homing done
    input wire [2:0] OP_MODE, // mode
    input wire [31:0] REF_SPEED, // speed in
    input wire [31:0] REF_SPEED_LIM, // speed out
    input wire [31:0] ACTIVE_DECEL, // decel out
    input wire [15:0] MOTOR_SPEED_LIMIT, // max speed
    input wire SOFT_LIMIT_POS_ENABLE, // pos monitor
    input wire SOFT_LIMIT_NEG_ENABLE // neg monitor
);
    localparam int CEIL = 13200;
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    sequence s_hi;
        WR_EN && ADDR == 16'h0624;
    endsequence
    sequence s_lo;
        WR_EN && ADDR == 16'h0625;
    endsequence
    property p_clamp_on;
        OP_MODE inside {3'h1, 3'h2, 3'h3, 3'h4} |=>
            $signed(REF_SPEED_LIM) <= CEIL && $signed(REF_SPEED_LIM) >= -CEIL;
    endproperty
    a_clamp_on: assert property (p_clamp_on) else $error("speed above ceiling");
    property p_clamp_off;
        !(OP_MODE inside {3'h1, 3'h2, 3'h3, 3'h4}) |=> REF_SPEED_LIM == $past(REF_SPEED);
    endproperty
    a_clamp_off: assert property (p_clamp_off) else $error("speed altered");
    property p_decel_rng;
        ACTIVE_DECEL >= 32'h000000c8 && ACTIVE_DECEL <= 32'h002dc6c0;
    endproperty
    a_decel_rng: assert property (p_decel_rng) else $error("decel out of range");
    property p_home_gate;
        !HOMING_VALID |=> !SOFT_LIMIT_POS_ENABLE && !SOFT_LIMIT_NEG_ENABLE;
    endproperty
    a_home_gate: assert property (p_home_gate) else $error("monitor without homing");
    property p_predef_ro;
        PREDEF_MOTOR && WR_EN && ADDR inside {16'h0e14, 16'h0e16, 16'h0e18} |=> WR_ERR;
    endproperty
    a_predef_ro: assert property (p_predef_ro) else $error("torque speed written");
    property p_modes_ro;
        WR_EN && ADDR == 16'h1b29 |=> WR_ERR;
    endproperty
    a_modes_ro: assert property (p_modes_ro) else $error("mode mask written");
    property p_spd_bad;
        WR_EN && ADDR == 16'h0e08 && (WR_DATA == 16'h0000 || WR_DATA > 16'h0bb8) |=> WR_ERR;
    endproperty
    a_spd_bad: assert property (p_spd_bad) else $error("bad speed accepted");
    property p_lone_lo;
        !$past(WR_EN && ADDR == 16'h0624) ##0 s_lo |=> WR_ERR;
    endproperty
    a_lone_lo: assert property (p_lone_lo) else $error("lone low word taken");
    property p_pair;
        s_hi ##1 s_lo |=> WR_ERR == ({$past(WR_DATA, 2), $past(WR_DATA)} < 32'h000000c8 ||
            {$past(WR_DATA, 2), $past(WR_DATA)} > 32'h002dc6c0);
    endproperty
    a_pair: assert property (p_pair) else $error("stop decel check wrong");
    property p_rd_valid;
        RD_VALID == $past(RD_EN);
    endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("read not answered");
endmodule
////////////////////////////////////////////////////////////////
bind mpb_bank mpb_bank_props u_props (.CLK(CLK), .RST(RST), .WR_EN(WR_EN), .ADDR(ADDR),
    .WR_DATA(WR_DATA), .WR_ERR(WR_ERR), .RD_EN(RD_EN), .RD_VALID(RD_VALID),
    .PREDEF_MOTOR(PREDEF_MOTOR),
    .HOMING_VALID(HOMING_VALID), .OP_MODE(OP_MODE), .REF_SPEED(REF_SPEED),
    .REF_SPEED_LIM(REF_SPEED_LIM), .ACTIVE_DECEL(ACTIVE_DECEL),
    .MOTOR_SPEED_LIMIT(MOTOR_SPEED_LIMIT), .SOFT_LIMIT_POS_ENABLE(SOFT_LIMIT_POS_ENABLE),
    .SOFT_LIMIT_NEG_ENABLE(SOFT_LIMIT_NEG_ENABLE));

/* File: testbench/mpb_master.sv */
`timescale 1ns/10ps
module mpb_master (
    input wire clk, // clock
    input wire [15:0] rd_data, // read word
    input wire wr_err, // reject pulse
    output reg wr_en, // write strobe
    output reg rd_en, // read strobe
    output reg [15:0] addr, // word address
    output reg [15:0] wr_data // write word
);
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 16'h0000;
        wr_data = 16'h0000;
    end
    // strobes stay up between the words of a pair
    task word(input w, input [15:0] a, input [15:0] d, output [15:0] q, output e);
        begin
            wr_en = w;
            rd_en = !w;
            addr = a;
            wr_data = d;
            @(posedge clk);
            #1;
            q = rd_data;
            e = wr_err;
        end
    endtask
    ////////////////////////////////////////////////////////////////
    task xfer(input w, input wide, input [15:0] a, input [31:0] d, output [31:0] q,
        output e);
        reg [15:0] h;
        reg [15:0] l;
        reg eh;
        begin
            h = 16'h0000;
            eh = 1'b0;
            if (wide)
                word(w, a, d[31:16], h, eh);
            word(w, wide ? a + 16'h0001 : a, d[15:0], l, e);
            q = {h, l};
            e = e | eh;
            wr_en = 1'b0;
            rd_en = 1'b0;
            // released lines flip so a stale word never looks held
            addr = ~addr;
            wr_data = ~wr_data;
            repeat (2) @(posedge clk);
            #1;
        end
    endtask
endmodule

/* File: testbench/mpb_bank_tb.sv */
`timescale 1ns/10ps
`include "mpb_map.vh"
`define MPB_EQ(g, x) begin checks = checks + 1; if ((g) !== (x)) begin n_fail = n_fail + 1; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (g), (x)); end end
module mpb_bank_tb;
    reg clk, rst, predef, homing, swstop, ecls1, e, ex;
    reg [15:0] s20, s50, s90, seed;
    reg [31:0] umin, umax, refs, q, x, acc, dec, qs, v;
    reg [2:0] mode;
    reg [1:0] sel;
    wire wr_en, rd_en, rd_valid, wr_err, pen, nen;
    wire [15:0] addr, wr_data, rd_data, sss, msl, nomc;
    wire [31:0] ref_lim, adec, pacc, lpos, lneg;
    integer checks, n_fail, cyc, i;
    always #12.5 clk = ~clk;
    mpb_bank u_mpb_bank (.CLK(clk), .RST(rst), .WR_EN(wr_en), .RD_EN(rd_en), .ADDR(addr),
        .WR_DATA(wr_data), .RD_DATA(rd_data), .RD_VALID(rd_valid), .WR_ERR(wr_err),
        .PREDEF_MOTOR(predef), .PREDEF_SPD20(s20), .PREDEF_SPD50(s50), .PREDEF_SPD90(s90),
        .USER_POS_MIN(umin), .USER_POS_MAX(umax), .HOMING_VALID(homing), .SW_STOP(swstop),
        .ERR_CLASS1(ecls1), .OP_MODE(mode), .REF_SPEED(refs), .REF_SPEED_LIM(ref_lim),
        .ACTIVE_DECEL(adec), .PROFILE_ACCEL(pacc), .START_STOP_SPEED(sss),
        .MOTOR_SPEED_LIMIT(msl), .NOMINAL_CURRENT(nomc), .SOFT_LIMIT_POS_ENABLE(pen),
        .SOFT_LIMIT_NEG_ENABLE(nen), .SOFT_LIMIT_POS(lpos), .SOFT_LIMIT_NEG(lneg));
    mpb_master u_mpb_master (.clk(clk), .rd_data(rd_data), .wr_err(wr_err), .wr_en(wr_en),
        .rd_en(rd_en), .addr(addr), .wr_data(wr_data));
    function [15:0] lfsr(input [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function [15:0] sym_exp(input [31:0] a, input [31:0] d);
        reg [31:0] m;
        begin
            m = (a > d ? a : d) / 32'h0000000a;
            sym_exp = m > 32'h0000ffff ? 16'hffff : m[15:0];
        end
    endfunction
    function [31:0] clamp_exp(input [2:0] md, input [31:0] r);
        begin
            clamp_exp = r;
            if (md >= 3'h1 && md <= 3'h4 && $signed(r) > $signed(32'h00003390))
                clamp_exp = 32'h00003390;
            if (md >= 3'h1 && md <= 3'h4 && $signed(r) < $signed(32'hffffcc70))
                clamp_exp = 32'hffffcc70;
        end
    endfunction
    ////////////////////////////////////////////////////////////////
    task xw(input wide, input [15:0] a, input [31:0] d, input ee);
        begin
            u_mpb_master.xfer(1'b1, wide, a, d, q, e);
            `MPB_EQ(e, ee)
        end
    endtask
    task xr(input wide, input [15:0] a, input [31:0] xp);
        begin
            u_mpb_master.xfer(1'b0, wide, a, 32'h00000000, q, e);
            `MPB_EQ(q, xp)
        end
    endtask
    task settle;
        begin
            repeat (2) @(posedge clk);
            #1;
        end
    endtask
    task close_out;
        begin
            $display("checks=%0d n_fail=%0d", checks, n_fail);
            if (n_fail == 0 && checks > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            close_out;
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        {clk, rst, predef, homing, swstop, ecls1, mode, refs} = {2'b01, 39'h0};
        {s20, s50, s90, checks, n_fail, cyc, seed} = {144'h0, 16'h0035};
        umin = 32'hfffffc18;
        umax = 32'h00100000;
        repeat (4) @(posedge clk);
        #1;
        rst = 1'b0;
        `MPB_EQ(msl, 16'h0bb8)
        `MPB_EQ({lpos, lneg}, 64'h7fffffff80000000)
        xr(1, `MPB_A_QSTOP, 32'h00001770);
        xr(1, `MPB_A_MODES, 32'h007f0025);
        xr(0, `MPB_A_LIM_SEL, 32'h00000000);
        {acc, dec, qs, v} = {32'h00000258, 32'h000002ee, 32'h00001770, 32'h00000bb8};
        xr(0, `MPB_A_SYM_RAMP, sym_exp(acc, dec));
        xw(0, `MPB_A_REF_CEIL, 32'h0000003b, 1);
        xr(0, `MPB_A_REF_CEIL, 32'h00003390);
        xw(0, `MPB_A_MODES + 16'h0001, 32'h00000001, 1);
        xw(0, 16'h0700, 32'h00000001, 1);
        xw(0, `MPB_A_QSTOP + 16'h0001, 32'h00000001, 1);
        for (i = 0; i < 5; i = i + 1) begin
            seed = lfsr(seed);
            x = i == 0 ? 32'h13 : i == 1 ? 32'h14 : i == 2 ? 32'hffff : {16'h0, seed};
            ex = x < 32'h00000014;
            xw(0, `MPB_A_SYM_RAMP, x, ex);
            if (!ex)
                {acc, dec} = {2{x * 32'h0000000a}};
            `MPB_EQ(pacc, acc)
            xr(1, `MPB_A_PROF_DEC, dec);
            xr(0, `MPB_A_SYM_RAMP, sym_exp(acc, dec));
        end
        xw(1, `MPB_A_PROF_ACC, 32'h002dc6c1, 1);
        xw(1, `MPB_A_PROF_ACC, 32'h002dc6c0, 0);
        xr(0, `MPB_A_SYM_RAMP, 32'h0000ffff);
        for (i = 0; i < 5; i = i + 1) begin
            seed = lfsr(seed);
            x = i == 0 ? 32'hc7 : i == 1 ? 32'hc8 : i == 2 ? 32'h2dc6c0 : {11'h0, seed, 5'h1};
            x = i == 3 ? 32'h002dc6c1 : x;
            ex = x < 32'h000000c8 || x > 32'h002dc6c0;
            xw(1, `MPB_A_QSTOP, x, ex);
            if (!ex)
                qs = x;
            {swstop, ecls1} = {i[0], !i[0]};
            settle;
            `MPB_EQ(adec, qs)
            {swstop, ecls1} = 2'b00;
        end
        settle;
        `MPB_EQ(adec, dec)
        seed = lfsr(seed);
        xw(0, `MPB_A_START_STOP, {16'h0, seed}, 0);
        `MPB_EQ(sss, seed)
        seed = lfsr(seed);
        xw(0, `MPB_A_NOM_CUR, {16'h0, seed}, 0);
        `MPB_EQ(nomc, seed)
        for (i = 0; i < 4; i = i + 1) begin
            x = i == 0 ? 32'h0 : i == 1 ? 32'h1 : i == 2 ? 32'h0bb8 : 32'h0bb9;
            ex = x == 32'h0 || x > 32'h00000bb8;
            xw(0, `MPB_A_SPD_LIMIT, x, ex);
            if (!ex)
                v = x;
            `MPB_EQ(msl, v[15:0])
        end
        sel = 2'b00;
        for (i = 0; i < 10; i = i + 1) begin
            homing = i[0];
            x = i >> 1;
            xw(0, `MPB_A_LIM_SEL, x, x > 32'h3);
            if (x < 32'h4)
                sel = x[1:0];
            `MPB_EQ({pen, nen}, {homing & sel[0], homing & sel[1]})
        end
        for (i = 0; i < 3; i = i + 1) begin
            seed = lfsr(seed);
            x = i == 0 ? {16'h0, seed} : i == 1 ? umax + 32'h1 : umin - 32'h1;
            ex = $signed(x) > $signed(umax) || $signed(x) < $signed(umin);
            xw(1, `MPB_A_LIM_POS, x, 0);
            `MPB_EQ(lpos, ex ? umax : x)
            xw(1, `MPB_A_LIM_NEG, x, 0);
            `MPB_EQ(lneg, ex ? umax : x)
        end
        seed = lfsr(seed);
        {predef, s20, s50, s90} = {1'b1, seed, ~seed, seed ^ 16'h5a5a};
        settle;
        xr(0, `MPB_A_SPD20, {16'h0, s20});
        xr(0, `MPB_A_SPD50, {16'h0, s50});
        xr(0, `MPB_A_SPD90, {16'h0, s90});
        xw(0, `MPB_A_SPD20, 32'h00000123, 1);
        predef = 1'b0;
        xw(0, `MPB_A_SPD50, 32'h00000123, 0);
        xr(0, `MPB_A_SPD50, 32'h00000123);
        for (i = 0; i < 24; i = i + 1) begin
            seed = lfsr(seed);
            mode = i[2:0];
            refs = i < 8 ? 32'h00003391 : i < 16 ? 32'hffffcc6f : {seed, lfsr(seed)};
            settle;
            `MPB_EQ(ref_lim, clamp_exp(mode, refs))
        end
        close_out;
    end
endmodule
